/* File: design/event_router_pkg.sv */
// Shared constants and carrier types for the peripheral event router
package event_router_pkg;
    localparam int CHANNELS      = 6;
    localparam int GENERATORS    = 15;
    localparam int USERS         = 8;
    localparam int PORTS         = 4;
    localparam int GEN_SEL_W     = 4;
    localparam int CH_SEL_W      = 3;
    // Selection code zero means no connection
    localparam logic [GEN_SEL_W-1:0] GEN_NONE = 4'h0;
    localparam logic [CH_SEL_W-1:0]  CH_NONE  = 3'h0;
    // Synchroniser depth on the synchronous path
    localparam int SYNC_STAGES   = 2;

    // Per-channel pair of copies
    typedef struct packed {
        logic [CHANNELS-1:0] async_path;
        logic [CHANNELS-1:0] sync_path;
    } channel_bus_t;

    // Routing configuration as driven by software
    typedef struct packed {
        logic [CHANNELS-1:0][GEN_SEL_W-1:0] channel_generator_select;
        logic [USERS-1:0][CH_SEL_W-1:0]     user_channel_select;
        logic [PORTS-1:0][CH_SEL_W-1:0]     pin_channel_select;
    } route_cfg_t;
endpackage : event_router_pkg

/* File: design/peripheral_event_router.sv */
// Peripheral event router: generator muxes, channel sync and user muxes
`timescale 1ns/1ps

module peripheral_event_router
    import event_router_pkg::*;
#(
    parameter int NUM_CH = event_router_pkg::CHANNELS
)(
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    input  wire logic [event_router_pkg::GENERATORS-1:0]    gen_event,
    input  wire logic [event_router_pkg::GENERATORS-1:0]    gen_is_async,
    input  wire event_router_pkg::route_cfg_t               cfg,
    output logic [event_router_pkg::USERS-1:0]              user_sync_event,
    output logic [event_router_pkg::USERS-1:0]              user_async_event,
    output logic [event_router_pkg::PORTS-1:0]              event_pin_output,
    output logic [event_router_pkg::CHANNELS-1:0]           channel_sync_ff
);
    import event_router_pkg::*;

    // Selected generator per channel; code zero and codes past the
    // generator list read low, so a cleared select disconnects
    function automatic logic pick_gen(
        input logic [GENERATORS-1:0] ev,
        input logic [GEN_SEL_W-1:0]  sel
    );
        logic r;
        r = 1'b0;
        if (sel != GEN_NONE && int'(sel) <= GENERATORS)
            r = ev[int'(sel) - 1];
        return r;
    endfunction : pick_gen

    // Channel pick for users and pins; code k means channel k-1
    function automatic logic pick_ch(
        input logic [CHANNELS-1:0] ch,
        input logic [CH_SEL_W-1:0] sel
    );
        logic r;
        r = 1'b0;
        if (sel != CH_NONE && int'(sel) <= CHANNELS)
            r = ch[int'(sel) - 1];
        return r;
    endfunction : pick_ch

    channel_bus_t        chan;
    logic [CHANNELS-1:0] src_async;
    logic [CHANNELS-1:0] meta_ff;
    logic [CHANNELS-1:0] nxt_meta;
    logic [CHANNELS-1:0] nxt_sync;
    logic [USERS-1:0]    user_async_ff;
    logic [USERS-1:0]    user_sync_ff;
    logic [PORTS-1:0]    pin_ff;
    logic [USERS-1:0]    nxt_user_async;
    logic [USERS-1:0]    nxt_user_sync;
    logic [PORTS-1:0]    nxt_pin;

    // Generator muxes; the async copy has no clock in its path
    // Counter ticks, debug sync and comparators arrive as async levels
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
        begin
            chan.async_path[c] = pick_gen(gen_event,
                cfg.channel_generator_select[c]);
            src_async[c] = pick_gen(gen_is_async,
                cfg.channel_generator_select[c]);
        end
    end

    // Two-stage synchroniser; stage one feeds only stage two
    always_comb
    begin
        nxt_meta = chan.async_path;
        nxt_sync = meta_ff;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff         <= '0;
            channel_sync_ff <= '0;
        end
        else
        begin
            meta_ff         <= nxt_meta;
            channel_sync_ff <= nxt_sync;
        end
    end

    // Sync copy: synchronised for async sources, direct for clk sources
    always_comb
    begin
        for (int c = 0; c < CHANNELS; c++)
            chan.sync_path[c] = src_async[c] ? channel_sync_ff[c]
                                             : chan.async_path[c];
    end

    // Per-user and per-pin channel multiplexers
    always_comb
    begin
        for (int u = 0; u < USERS; u++)
        begin
            nxt_user_async[u] = pick_ch(chan.async_path,
                cfg.user_channel_select[u]);
            nxt_user_sync[u]  = pick_ch(chan.sync_path,
                cfg.user_channel_select[u]);
        end
        for (int p = 0; p < PORTS; p++)
            nxt_pin[p] = pick_ch(chan.async_path,
                cfg.pin_channel_select[p]);
    end

    // Output registers; outputs must come from flip-flops, which costs
    // one cycle on the async copy as seen at the ports
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            user_async_ff <= '0;
            user_sync_ff  <= '0;
            pin_ff        <= '0;
        end
        else
        begin
            user_async_ff <= nxt_user_async;
            user_sync_ff  <= nxt_user_sync;
            pin_ff        <= nxt_pin;
        end
    end

    assign user_async_event = user_async_ff;
    assign user_sync_event  = user_sync_ff;
    assign event_pin_output = pin_ff;

    // Assertions
    property p_sync_lag;
        @(posedge clk) disable iff (rst)
        chan.async_path[0] |-> ##2 channel_sync_ff[0];
    endproperty
    a_sync_lag: assert property (p_sync_lag)
        else $error("sync stage did not follow");

    property p_sync_two;
        @(posedge clk) disable iff (rst)
        ($rose(chan.async_path[0]) && $stable(cfg)) ##1 $stable(cfg)
            ##1 $stable(cfg)
            |-> channel_sync_ff[0] || !$past(chan.async_path[0]);
    endproperty
    a_sync_two: assert property (p_sync_two)
        else $error("sync path latency wrong");

    property p_none_low;
        @(posedge clk) disable iff (rst)
        cfg.channel_generator_select[0] == GEN_NONE |-> !chan.async_path[0];
    endproperty
    a_none_low: assert property (p_none_low)
        else $error("unselected channel carries event");

    property p_user_follow;
        @(posedge clk) disable iff (rst)
        cfg.user_channel_select[0] == 3'h1 |=>
            user_async_event[0] == $past(chan.async_path[0]);
    endproperty
    a_user_follow: assert property (p_user_follow)
        else $error("user mux not following channel");

    property p_user_none;
        @(posedge clk) disable iff (rst)
        cfg.user_channel_select[0] == CH_NONE |=> !user_sync_event[0];
    endproperty
    a_user_none: assert property (p_user_none)
        else $error("unconnected user active");

    property p_pin_follow;
        @(posedge clk) disable iff (rst)
        cfg.pin_channel_select[0] == 3'h2 |=>
            event_pin_output[0] == $past(chan.async_path[1]);
    endproperty
    a_pin_follow: assert property (p_pin_follow)
        else $error("pin does not follow channel");

    property p_gen_pick;
        @(posedge clk) disable iff (rst)
        cfg.channel_generator_select[1] == 4'h1 |->
            chan.async_path[1] == gen_event[0];
    endproperty
    a_gen_pick: assert property (p_gen_pick)
        else $error("channel not carrying chosen generator");

    property p_level_hold;
        @(posedge clk) disable iff (rst)
        (cfg.user_channel_select[0] == 3'h1 && !src_async[0]) |=>
            user_sync_event[0] == $past(chan.async_path[0]);
    endproperty
    a_level_hold: assert property (p_level_hold)
        else $error("sync level altered");

    // Last channel works on its own, away from channel zero
    property p_last_channel;
        @(posedge clk) disable iff (rst)
        cfg.channel_generator_select[5] == 4'hf |->
            chan.async_path[5] == gen_event[14];
    endproperty
    a_last_channel: assert property (p_last_channel)
        else $error("sixth channel not carrying its generator");
endmodule : peripheral_event_router

/* File: testbench/event_source_bank.sv */
// Generator bank model standing on the router's far side
`timescale 1ns/1ps
module event_source_bank (
    input  wire logic        clk,
    input  wire logic [3:0]  fire_code,
    input  wire logic        fire_async,
    input  wire logic [3:0]  fire_len,
    output logic      [14:0] gen_event,
    output logic      [14:0] gen_is_async
);
    int left = 0;
    int idx  = 0;
    int dly  = 0;
    initial gen_event = 15'h0;
    initial gen_is_async = 15'h0;
    // Foreign sources move 13 ns off the edge, never on it
    always @(posedge clk)
    begin
        if (fire_code != 4'h0)
        begin
            idx = fire_code - 1;
            dly = fire_async ? 13 : 0;
            left = fire_len;
            gen_is_async[idx] <= fire_async;
            gen_event[idx] <= #(dly) 1'b1;
        end
        else if (left > 0)
        begin
            left = left - 1;
            if (left == 0)
                gen_event[idx] <= #(dly) 1'b0;
        end
    end
endmodule : event_source_bank

/* File: testbench/tb_peripheral_event_router.sv */
// Self-checking bench for the peripheral event router
`timescale 1ns/1ps
module tb_peripheral_event_router;
    import event_router_pkg::*;
    typedef struct packed {int cyc; logic [11:0] val;} note_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  fire_code = 4'h0;
    logic        fire_async = 1'b0;
    logic [3:0]  fire_len = 4'h1;
    logic [14:0] gen_event;
    logic [14:0] gen_is_async;
    route_cfg_t  cfg = '0;
    logic [7:0]  user_sync_event;
    logic [7:0]  user_async_event;
    logic [3:0]  event_pin_output;
    logic [11:0] a_prev = 12'h0;
    logic [7:0]  s_prev = 8'h0;
    logic [31:0] seed = 32'h44;
    logic [5:0]  chan_sync;
    logic [5:0]  ch_now = 6'h0;
    logic [5:0]  h1 = 6'h0;
    logic [5:0]  h2 = 6'h0;
    logic        any_out = 1'b0;
    wire  [11:0] a_now = {event_pin_output, user_async_event};
    note_t       qa[$];
    note_t       qs[$];
    int          cyc = 0;
    int          fails = 0;
    int          checks_done = 0;
    event_source_bank u_bank (.clk(clk), .fire_code(fire_code),
        .fire_async(fire_async), .fire_len(fire_len),
        .gen_event(gen_event), .gen_is_async(gen_is_async));
    peripheral_event_router u_dut (.clk(clk), .rst(rst),
        .gen_event(gen_event), .gen_is_async(gen_is_async), .cfg(cfg),
        .user_sync_event(user_sync_event),
        .user_async_event(user_async_event),
        .event_pin_output(event_pin_output), .channel_sync_ff(chan_sync));
    initial forever #25 clk = ~clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    function automatic logic hit(route_cfg_t c, logic [2:0] s,
                                 logic [3:0] g);
        return s != 3'h0 && s <= 3'h6
            && c.channel_generator_select[s - 1] === g;
    endfunction : hit
    task automatic judge(ref note_t q[$], input logic [11:0] got);
        note_t n;
        checks_done++;
        if (q.size() == 0)
            n = '{-1, 12'h0};
        else
            n = q.pop_front();
        if (n.cyc != cyc || n.val !== got)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, n.val);
        end
    endtask : judge
    task automatic close_out();
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : close_out
    // Rising results are matched with the oldest note, cycle exact
    always @(negedge clk)
    begin
        cyc++;
        if (!rst && a_prev === 12'h0 && a_now !== 12'h0)
            judge(qa, a_now);
        if (!rst && s_prev === 8'h0 && user_sync_event !== 8'h0)
            judge(qs, {4'h0, user_sync_event});
        a_prev = a_now;
        s_prev = user_sync_event;
        // Channel model: second stage shows the level two edges back
        for (int c = 0; c < 6; c++)
            ch_now[c] = cfg.channel_generator_select[c] != 4'h0
                && gen_event[cfg.channel_generator_select[c] - 4'h1];
        if (!rst && {a_now, user_sync_event, chan_sync} !== 26'h0)
            any_out = 1'b1;
        if (!rst)
        begin
            checks_done++;
            if (chan_sync !== h2)
            begin
                fails++;
                $display("[FAIL] %0t sync stage %h exp %h", $time,
                         chan_sync, h2);
            end
        end
        h2 = h1;
        h1 = ch_now;
    end
    task automatic fire(input logic [3:0] g, input logic a,
        input logic [3:0] n, input logic [11:0] av, input logic [7:0] sv);
        @(posedge clk);
        fire_code <= g;
        fire_async <= a;
        fire_len <= n;
        if (av != 12'h0)
            qa.push_back('{cyc + 3, av});
        if (sv != 8'h0)
            qs.push_back('{cyc + (a ? 5 : 3), sv});
        @(posedge clk);
        fire_code <= 4'h0;
        repeat (10) @(posedge clk);
    endtask : fire
    // Random routing; expectations rebuilt from the selects
    task automatic trial(input int t);
        route_cfg_t  c;
        logic [3:0]  g;
        logic [11:0] av;
        seed = xs(seed);
        c[31:0] = seed;
        seed = xs(seed);
        c[59:32] = seed[27:0];
        g = 4'(seed % 15 + 1);
        c.channel_generator_select[t % 6] = g;
        c.user_channel_select[t % 8] = 3'(t % 6 + 1);
        av = 12'h0;
        for (int u = 0; u < 8; u++)
            av[u] = hit(c, c.user_channel_select[u], g);
        for (int p = 0; p < 4; p++)
            av[8 + p] = hit(c, c.pin_channel_select[p], g);
        @(posedge clk);
        cfg.channel_generator_select <= c.channel_generator_select;
        @(posedge clk);
        cfg <= c;
        fire(g, 1'(t % 2), 4'(1 + t % 4), av, av[7:0]);
        $display("test %0d done", t);
    endtask : trial
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // Nothing routed yet, so a firing source stays unseen
        fire(4'h5, 1'b1, 4'h2, 12'h0, 8'h0);
        checks_done++;
        if (any_out !== 1'b0)
        begin
            fails++;
            $display("[FAIL] %0t unrouted event seen", $time);
        end
        $display("test reset done");
        for (int t = 0; t < 12; t++)
            trial(t);
        if (qa.size() != 0 || qs.size() != 0)
        begin
            fails++;
            $display("[FAIL] %0t events missing", $time);
        end
        close_out();
    end
    // Run needs about 200 cycles; this bound is far beyond it
    initial
    begin
        #(2500 * 50);
        fails++;
        $display("[FAIL] %0t watchdog", $time);
        close_out();
    end
endmodule : tb_peripheral_event_router
